// [rtl/tcc_cfg.svh]
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define TCC_CONTROL_IDX 30'h0000_7420
`define TCC_STATUS_IDX 30'h0000_7422
`define TCC_FLAG_IDX 30'h0000_7424
`define TCC_MASK_IDX 30'h0000_7425
`define TCC_TOP_IDX 30'h0000_7428
`define TCC_BOTTOM_IDX 30'h0000_742C

// ************************************************************
// reset values and writable bits
// ************************************************************
`define TCC_CONTROL_RESET 16'h0000
`define TCC_CONTROL_WMASK 16'h77FC
`define TCC_STATUS_WMASK 16'h3F00
`define TCC_FLAG_RESET 3'h0
`define TCC_MASK_RESET 3'h0

// ************************************************************
// field positions and counts
// ************************************************************
`define TCC_CLEAR_BIT 15
`define TCC_QUEUE_LSB 8
`define TCC_NUM_CH 3
`define TCC_WORD_SIZE 3'h2

`endif

// [rtl/tcc_pkg.sv]
package tcc_pkg;

  // pair mode field of the control register
  typedef enum logic [1:0] {
    PAIR_OFF = 2'b00,
    PAIR_CAPTURE = 2'b01,
    PAIR_RESERVED = 2'b10,
    PAIR_DECODER = 2'b11
  } tcc_pair_mode_type;

  // edge select field
  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } tcc_edge_type;

  // queue state field
  typedef enum logic [1:0] {
    QUEUE_EMPTY = 2'b00,
    QUEUE_ONE = 2'b01,
    QUEUE_TWO = 2'b10,
    QUEUE_LOST = 2'b11
  } tcc_queue_type;

  // control register layout, msb first
  typedef struct packed {
    logic capture_clear_strobe;
    tcc_pair_mode_type pair_or_decoder_select;
    logic channel_three_enable;
    logic reserved_high;
    logic channel_three_timebase_select;
    logic channel_pair_timebase_select;
    logic channel_three_converter_trigger;
    tcc_edge_type channel_one_edge_select;
    tcc_edge_type channel_two_edge_select;
    tcc_edge_type channel_three_edge_select;
    logic [1:0] reserved_low;
  } tcc_control_type;

  // latched bus address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [29:0] index;
  } tcc_bus_req_type;

endpackage : tcc_pkg

// [rtl/tcc_capture.sv]
`timescale 1ns/10ps
`include "tcc_cfg.svh"

module tcc_capture import tcc_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // capture pins
  input wire logic [2:0] capture_pin,
  // timer counts, same clock
  input wire logic [15:0] timer_one_count,
  input wire logic [15:0] timer_two_count,
  // event outputs
  output logic [2:0] event_flag,
  output logic capture_request,
  output logic converter_start,
  output logic decoder_enable,
  output logic decoder_clear
);

  // ************************************************************
  // declarations
  // ************************************************************
  tcc_control_type ctrl; // control register
  logic [2:0] flag_mask; // mask for event flags
  tcc_bus_req_type dphase; // latched address phase
  logic accept; // address phase taken
  logic [29:0] a_index; // word index of address phase
  logic wr_en; // data phase write
  logic ctrl_wr; // control register write
  logic status_wr; // status register write
  logic flag_wr; // flag register write
  logic mask_wr; // mask register write
  logic clear; // software clear strobe
  logic [2:0] pin_meta; // first sync stage
  logic [2:0] pin_sync; // second sync stage
  logic [2:0] pin_prev; // previous synced sample
  logic [2:0] rise; // rising edge seen
  logic [2:0] fall; // falling edge seen
  logic [2:0] ch_en; // channel enable
  logic [2:0] cap; // capture this cycle
  logic [2:0] pop_top; // top entry read
  logic [2:0] pop_bot; // bottom entry read
  logic pair_en; // channels one and two on
  tcc_edge_type edge_sel [3]; // edge select per channel
  logic [15:0] stamp [3]; // chosen timer value
  tcc_queue_type status [3]; // queue state
  tcc_queue_type next_status [3]; // next queue state
  logic [15:0] top_entry [3]; // oldest value
  logic [15:0] bot_entry [3]; // newer value
  logic [15:0] next_top [3]; // next oldest
  logic [15:0] next_bot [3]; // next newer
  logic set_flag [3]; // flag set event
  logic [15:0] next_rdata; // read mux result

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // ************************************************************
  // bus decode
  // ************************************************************

  // address phase taken on word access
  assign accept = hsel & hready & htrans[1] & (hsize == `TCC_WORD_SIZE);
  assign a_index = haddr[31:2];
  assign wr_en = dphase.valid & dphase.write;
  assign ctrl_wr = wr_en & (dphase.index == `TCC_CONTROL_IDX);
  assign status_wr = wr_en & (dphase.index == `TCC_STATUS_IDX);
  assign flag_wr = wr_en & (dphase.index == `TCC_FLAG_IDX);
  assign mask_wr = wr_en & (dphase.index == `TCC_MASK_IDX);
  // zero in bit 15 clears control, mask, queues and flags
  assign clear = ctrl_wr & ~hwdata[`TCC_CLEAR_BIT];

  // latch address phase for the data phase
  always_ff @(posedge clock) begin
    if (!resetn) begin
      dphase <= '0;
    end else if (hready) begin
      dphase.valid <= accept & (haddr[1:0] == 2'h0);
      dphase.write <= hwrite;
      dphase.index <= a_index;
    end
  end

  // pops happen at the address phase of a read
  always_comb begin
    for (int j = 0; j < `TCC_NUM_CH; j++) begin
      pop_top[j] = accept & ~hwrite & (haddr[1:0] == 2'h0) & (a_index == `TCC_TOP_IDX + 30'(j));
      pop_bot[j] = accept & ~hwrite & (haddr[1:0] == 2'h0) & (a_index == `TCC_BOTTOM_IDX + 30'(j));
    end
  end

  // read mux, reserved bits zero
  always_comb begin
    next_rdata = 16'h0000;
    if (a_index == `TCC_CONTROL_IDX) begin
      next_rdata = ctrl & `TCC_CONTROL_WMASK;
    end else if (a_index == `TCC_STATUS_IDX) begin
      next_rdata = {2'h0, status[2], status[1], status[0], 8'h00};
    end else if (a_index == `TCC_FLAG_IDX) begin
      next_rdata = {13'h0000, event_flag};
    end else if (a_index == `TCC_MASK_IDX) begin
      next_rdata = {13'h0000, flag_mask};
    end else begin
      for (int j = 0; j < `TCC_NUM_CH; j++) begin
        if (a_index == `TCC_TOP_IDX + 30'(j)) begin
          next_rdata = top_entry[j];
        end
        if (a_index == `TCC_BOTTOM_IDX + 30'(j)) begin
          next_rdata = bot_entry[j];
        end
      end
    end
  end

  // read data registered at address phase, stands in data phase
  always_ff @(posedge clock) begin
    if (!resetn) begin
      hrdata <= 32'h0000_0000;
    end else if (accept & ~hwrite) begin
      hrdata <= (haddr[1:0] == 2'h0) ? {16'h0000, next_rdata} : 32'h0000_0000;
    end
  end

  // zero wait state, always okay
  always_ff @(posedge clock) begin
    if (!resetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ************************************************************
  // control and mask registers
  // ************************************************************

  // control register, reset and clear to zero
  always_ff @(posedge clock) begin
    if (!resetn || clear) begin
      ctrl <= `TCC_CONTROL_RESET;
    end else if (ctrl_wr) begin
      ctrl <= hwdata[15:0] & `TCC_CONTROL_WMASK;
    end
  end

  // flag mask register
  always_ff @(posedge clock) begin
    if (!resetn || clear) begin
      flag_mask <= `TCC_MASK_RESET;
    end else if (mask_wr) begin
      flag_mask <= hwdata[2:0];
    end
  end

  // ************************************************************
  // pin synchronisers and edge detect
  // ************************************************************

  // two flip-flops, then the previous sample
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
      pin_prev <= 3'h0;
    end else begin
      pin_meta <= capture_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // compare current and previous synced samples
  assign rise = pin_sync & ~pin_prev;
  assign fall = ~pin_sync & pin_prev;

  // pair mode selects capture or decoder
  assign pair_en = (ctrl.pair_or_decoder_select == PAIR_CAPTURE);
  // channel three has its own enable
  assign ch_en = {ctrl.channel_three_enable, pair_en, pair_en};
  assign edge_sel[0] = ctrl.channel_one_edge_select;
  assign edge_sel[1] = ctrl.channel_two_edge_select;
  assign edge_sel[2] = ctrl.channel_three_edge_select;

  // ************************************************************
  // per channel capture queue
  // ************************************************************
  for (genvar i = 0; i < `TCC_NUM_CH; i++) begin : g_ch

    // gate edges by field and enable
    assign cap[i] = ch_en[i] & ((edge_sel[i][0] & rise[i]) | (edge_sel[i][1] & fall[i]));

    // time base: one means timer one, zero timer two
    if (i == 2) begin : g_own
      assign stamp[i] = ctrl.channel_three_timebase_select ? timer_one_count : timer_two_count;
    end else begin : g_pair
      assign stamp[i] = ctrl.channel_pair_timebase_select ? timer_one_count : timer_two_count;
    end

    // queue next state: pops first, then capture, then software
    always_comb begin
      next_status[i] = status[i];
      next_top[i] = top_entry[i];
      next_bot[i] = bot_entry[i];
      set_flag[i] = 1'b0;
      // top read moves bottom up
      if (pop_top[i]) begin
        case (status[i])
          QUEUE_EMPTY: next_status[i] = QUEUE_EMPTY;
          QUEUE_ONE: next_status[i] = QUEUE_EMPTY;
          default: begin
            next_top[i] = bot_entry[i];
            next_status[i] = QUEUE_ONE;
          end
        endcase
      end
      // bottom read steps state down
      if (pop_bot[i]) begin
        case (status[i])
          QUEUE_EMPTY: next_status[i] = QUEUE_EMPTY;
          QUEUE_ONE: next_status[i] = QUEUE_EMPTY;
          default: next_status[i] = QUEUE_ONE;
        endcase
      end
      // capture writes the queue
      if (cap[i]) begin
        set_flag[i] = (status[i] != QUEUE_EMPTY);
        case (next_status[i])
          QUEUE_EMPTY: begin
            next_top[i] = stamp[i];
            next_status[i] = QUEUE_ONE;
          end
          QUEUE_ONE: begin
            next_bot[i] = stamp[i];
            next_status[i] = QUEUE_TWO;
          end
          default: begin
            // full: oldest lost
            next_top[i] = next_bot[i];
            next_bot[i] = stamp[i];
            next_status[i] = QUEUE_LOST;
          end
        endcase
      end
      // software write wins
      if (status_wr) begin
        next_status[i] = tcc_queue_type'(hwdata[`TCC_QUEUE_LSB + 2 * i +: 2]);
      end
    end

    // queue registers, cleared by reset or clear strobe
    always_ff @(posedge clock) begin
      if (!resetn || clear) begin
        status[i] <= QUEUE_EMPTY;
        top_entry[i] <= 16'h0000;
        bot_entry[i] <= 16'h0000;
      end else begin
        status[i] <= next_status[i];
        top_entry[i] <= next_top[i];
        bot_entry[i] <= next_bot[i];
      end
    end

    // ----- checks per channel -----
    capture_latency_a: assert property (
      cap[i] |-> $past(capture_pin[i], 2) != $past(capture_pin[i], 3))
      else $error("capture not two cycles after pin edge");
    gated_off_a: assert property (
      (!ch_en[i] || edge_sel[i] == EDGE_NONE) |-> !cap[i])
      else $error("disabled channel captured");
    first_copy_a: assert property (
      cap[i] && status[i] == QUEUE_EMPTY && !status_wr && !clear && !pop_top[i] && !pop_bot[i]
      |=> top_entry[i] == $past(stamp[i]) && status[i] == QUEUE_ONE)
      else $error("first capture not stored on top");
    queue_overflow_a: assert property (
      cap[i] && status[i] == QUEUE_TWO && !status_wr && !clear && !pop_top[i] && !pop_bot[i]
      |=> status[i] == QUEUE_LOST && top_entry[i] == $past(bot_entry[i]) && bot_entry[i] == $past(stamp[i]))
      else $error("overflow capture wrong");
    write_wins_a: assert property (
      status_wr && cap[i] && !clear |=> status[i] == $past(hwdata[`TCC_QUEUE_LSB + 2 * i +: 2]))
      else $error("status write lost to capture");
    flag_set_a: assert property (
      cap[i] && status[i] != QUEUE_EMPTY && !clear |=> event_flag[i] ##1 (capture_request || !$past(flag_mask[i])))
      else $error("flag not set by second capture");
  end

  // ************************************************************
  // event flags and outputs
  // ************************************************************

  // sticky flags, write one clears, set beats clear
  always_ff @(posedge clock) begin
    if (!resetn || clear) begin
      event_flag <= `TCC_FLAG_RESET;
    end else begin
      for (int j = 0; j < `TCC_NUM_CH; j++) begin
        if (set_flag[j]) begin
          event_flag[j] <= 1'b1;
        end else if (flag_wr && hwdata[j]) begin
          event_flag[j] <= 1'b0;
        end
      end
    end
  end

  // request only for unmasked flags
  always_ff @(posedge clock) begin
    if (!resetn) begin
      capture_request <= 1'b0;
    end else begin
      capture_request <= |(event_flag & flag_mask);
    end
  end

  // converter start when channel three flag becomes set
  always_ff @(posedge clock) begin
    if (!resetn) begin
      converter_start <= 1'b0;
    end else begin
      converter_start <= ~clear & set_flag[2] & ~event_flag[2] & ctrl.channel_three_converter_trigger;
    end
  end

  // decoder mode and clear towards the decoder
  always_ff @(posedge clock) begin
    if (!resetn) begin
      decoder_enable <= 1'b0;
      decoder_clear <= 1'b0;
    end else begin
      decoder_enable <= (ctrl.pair_or_decoder_select == PAIR_DECODER) & ~clear;
      decoder_clear <= clear;
    end
  end

  // timer counts are only sampled, never driven back

  // ************************************************************
  // module level checks
  // ************************************************************
  flag_request_a: assert property (
    (event_flag & flag_mask) == 3'h0 |=> !capture_request)
    else $error("request raised for masked flags");
  clear_all_a: assert property (
    clear |=> ctrl == `TCC_CONTROL_RESET && status[0] == QUEUE_EMPTY && status[1] == QUEUE_EMPTY
    && status[2] == QUEUE_EMPTY && event_flag == 3'h0 && decoder_clear)
    else $error("clear strobe left state behind");
  reserved_read_a: assert property (
    accept && !hwrite && haddr == {`TCC_CONTROL_IDX, 2'h0}
    |=> hrdata[15] == 1'b0 && hrdata[11] == 1'b0 && hrdata[1:0] == 2'h0)
    else $error("reserved control bits read nonzero");
  converter_start_a: assert property (
    converter_start |-> $past(ctrl.channel_three_converter_trigger) && event_flag[2] && !$past(event_flag[2]))
    else $error("converter start without new flag");
  pair_mode_a: assert property (
    ctrl.pair_or_decoder_select != PAIR_CAPTURE |-> cap[1:0] == 2'h0)
    else $error("pair captured outside capture mode");

  overflow_c: cover property (status[0] == QUEUE_TWO ##1 status[0] == QUEUE_LOST);
  converter_c: cover property (converter_start);
  pop_c: cover property (status[2] == QUEUE_TWO && pop_top[2] ##1 status[2] == QUEUE_ONE);
  write_race_c: cover property (status_wr && cap[0]);

endmodule : tcc_capture

// [sim/tcc_pin_source.sv]
`timescale 1ns/10ps

// ************************************************************
// edge source for the three capture pins
// ************************************************************
module tcc_pin_source (
  // clock
  input wire logic clock,
  // capture pins
  output logic [2:0] capture_pin
);
  // pins idle low
  initial begin
    capture_pin = 3'h0;
  end

  // change one pin just after an edge, then hold it two edges
  task automatic drive(input int ch, input logic lvl);
    capture_pin[ch] <= lvl;
    repeat (2) @(posedge clock);
  endtask : drive
endmodule : tcc_pin_source

// [sim/tb_top.sv]
`timescale 1ns/10ps
`include "tcc_cfg.svh"

// ************************************************************
// capture block bench
// ************************************************************
module tb_top import tcc_pkg::*; ;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, capture_request, converter_start, decoder_enable, decoder_clear;
  logic [2:0] capture_pin, event_flag;
  logic [15:0] tim1 = 16'h1000; // timer one, counts up
  logic [15:0] tim2 = 16'hF000; // timer two, counts down
  int errors = 0;
  int samples_checked = 0;
  int conv_n = 0; // converter starts seen
  logic [31:0] q, v1, v2, v3, v4;

  always #12.5 clock = ~clock;

  // timers and converter start counter
  always @(posedge clock) begin
    tim1 <= tim1 + 16'h0001;
    tim2 <= tim2 - 16'h0007;
    if (converter_start === 1'b1)
      conv_n <= conv_n + 1;
  end

  tcc_pin_source drv (.clock(clock), .capture_pin(capture_pin));

  tcc_capture uut (.clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .capture_pin(capture_pin), .timer_one_count(tim1),
    .timer_two_count(tim2), .event_flag(event_flag), .capture_request(capture_request),
    .converter_start(converter_start), .decoder_enable(decoder_enable),
    .decoder_clear(decoder_clear));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // wait for hready high at an edge, bounded
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      errors++;
      $display("[FAIL] hready expected 1 seen timeout");
      tally_and_finish;
    end
  endtask : wait_rdy

  // one single word transfer
  task automatic bus(input logic w, input logic [29:0] idx, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [29:0] idx, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask : wr

  task automatic rd(input string nm, input logic [29:0] idx, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, idx, 32'h0, r);
    chk(nm, e, r);
  endtask : rd

  // control word with the clear strobe held inactive
  function automatic logic [31:0] ctl(input logic [1:0] m, input logic en3, input logic ts3,
    input logic tsp, input logic trg, input logic [1:0] e1, input logic [1:0] e2, input logic [1:0] e3);
    return {16'h0, 1'b1, m, en3, 1'b0, ts3, tsp, trg, e1, e2, e3, 2'b00};
  endfunction : ctl

  // pin change; v is the count the block should store; fl checks a new flag
  task automatic cap(input int ch, input logic lvl, input logic sel, input logic fl, output logic [31:0] v);
    drv.drive(ch, lvl);
    #1;
    v = {16'h0, sel ? tim1 : tim2};
    if (fl)
      chk("flag early", 32'h0, {31'h0, event_flag[ch]});
    @(posedge clock);
    #1;
    if (fl)
      chk("flag set", 32'h1, {31'h0, event_flag[ch]});
    @(posedge clock);
  endtask : cap

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    rd("control", `TCC_CONTROL_IDX, 32'h0);
    rd("status", `TCC_STATUS_IDX, 32'h0);
    rd("flags", `TCC_FLAG_IDX, 32'h0);
    rd("unmapped", 30'h0000_7430, 32'h0);
    wr(`TCC_CONTROL_IDX, 32'h0000_FFFF);
    rd("control", `TCC_CONTROL_IDX, 32'h0000_77FC);
    chk("decoder", 32'h1, {31'h0, decoder_enable});
    wr(`TCC_STATUS_IDX, 32'h0000_FFFF);
    rd("status", `TCC_STATUS_IDX, 32'h0000_3F00);
    wr(`TCC_CONTROL_IDX, 32'h0000_7FFC);
    #1;
    chk("decoder clear", 32'h1, {31'h0, decoder_clear});
    @(posedge clock);
    #1;
    chk("decoder clear", 32'h0, {31'h0, decoder_clear});
    @(posedge clock);
    rd("control", `TCC_CONTROL_IDX, 32'h0);
    rd("status", `TCC_STATUS_IDX, 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp});
    $display("test reset done");
  endtask : t_reset

  task automatic t_queue;
    wr(`TCC_STATUS_IDX, 32'h0);
    wr(`TCC_CONTROL_IDX, ctl(2'h1, 1'b0, 1'b0, 1'b1, 1'b0, EDGE_RISE, EDGE_NONE, EDGE_NONE));
    wr(`TCC_MASK_IDX, 32'h1);
    cap(0, 1'b1, 1'b1, 1'b0, v1);
    cap(0, 1'b0, 1'b1, 1'b0, q);
    rd("ch1 one", `TCC_STATUS_IDX, 32'h0100);
    cap(0, 1'b1, 1'b1, 1'b1, v2);
    rd("ch1 two", `TCC_STATUS_IDX, 32'h0200);
    chk("request", 32'h1, {31'h0, capture_request});
    rd("ch1 top", `TCC_TOP_IDX, v1);
    rd("ch1 pop", `TCC_STATUS_IDX, 32'h0100);
    cap(0, 1'b0, 1'b1, 1'b0, q);
    cap(0, 1'b1, 1'b1, 1'b0, v3);
    cap(0, 1'b0, 1'b1, 1'b0, q);
    cap(0, 1'b1, 1'b1, 1'b0, v4);
    rd("ch1 lost", `TCC_STATUS_IDX, 32'h0300);
    rd("ch1 bottom", `TCC_BOTTOM_IDX, v4);
    rd("ch1 step", `TCC_STATUS_IDX, 32'h0100);
    rd("ch1 top", `TCC_TOP_IDX, v3);
    rd("ch1 empty", `TCC_STATUS_IDX, 32'h0);
    rd("flags", `TCC_FLAG_IDX, 32'h1);
    wr(`TCC_FLAG_IDX, 32'h1);
    rd("flags", `TCC_FLAG_IDX, 32'h0);
    chk("request", 32'h0, {31'h0, capture_request});
    $display("test queue done");
  endtask : t_queue

  // status write lands on the same edge as a capture update
  task automatic t_same;
    cap(0, 1'b0, 1'b1, 1'b0, q);
    cap(0, 1'b1, 1'b1, 1'b0, v1);
    cap(0, 1'b0, 1'b1, 1'b0, q);
    fork
      drv.drive(0, 1'b1);
      begin
        @(posedge clock);
        wr(`TCC_STATUS_IDX, 32'h0);
      end
    join
    repeat (2) @(posedge clock);
    rd("write wins", `TCC_STATUS_IDX, 32'h0);
    $display("test same cycle done");
  endtask : t_same

  // pair modes other than capture keep the queue untouched
  task automatic t_pair;
    logic [1:0] md [3];
    md = '{2'h0, 2'h2, 2'h3};
    wr(`TCC_CONTROL_IDX, ctl(2'h1, 1'b0, 1'b0, 1'b0, 1'b0, EDGE_BOTH, EDGE_BOTH, EDGE_NONE));
    cap(0, 1'b0, 1'b0, 1'b0, q);
    wr(`TCC_STATUS_IDX, 32'h0);
    cap(0, 1'b1, 1'b0, 1'b0, v1);
    for (int i = 0; i < 3; i++) begin
      wr(`TCC_CONTROL_IDX, ctl(md[i], 1'b0, 1'b0, 1'b0, 1'b0, EDGE_BOTH, EDGE_BOTH, EDGE_NONE));
      cap(0, 1'b0, 1'b0, 1'b0, q);
      cap(1, 1'b1, 1'b0, 1'b0, q);
      rd("pair off", `TCC_STATUS_IDX, 32'h0100);
      chk("decoder", {31'h0, md[i] == 2'h3}, {31'h0, decoder_enable});
      cap(0, 1'b1, 1'b0, 1'b0, q);
      cap(1, 1'b0, 1'b0, 1'b0, q);
    end
    rd("kept top", `TCC_TOP_IDX, v1);
    $display("test pair modes done");
  endtask : t_pair

  // every edge code on channel three, then disabled
  task automatic t_edges;
    logic [1:0] eg [5];
    int ne [5];
    logic [31:0] vr, vf;
    eg = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    ne = '{0, 1, 1, 2, 0};
    for (int i = 0; i < 5; i++) begin
      wr(`TCC_STATUS_IDX, 32'h0);
      wr(`TCC_CONTROL_IDX, ctl(2'h0, i < 4, 1'b0, 1'b0, 1'b0, EDGE_NONE, EDGE_NONE, eg[i]));
      cap(2, 1'b1, 1'b0, 1'b0, vr);
      cap(2, 1'b0, 1'b0, 1'b0, vf);
      rd("ch3 state", `TCC_STATUS_IDX, 32'(ne[i] << 12));
      if (ne[i] > 0)
        rd("ch3 top", `TCC_TOP_IDX + 30'h2, (eg[i] == 2'h2) ? vf : vr);
    end
    $display("test edges done");
  endtask : t_edges

  // converter start on channel three flag, then the clear strobe
  task automatic t_trig;
    int c0;
    wr(`TCC_FLAG_IDX, 32'h7);
    wr(`TCC_STATUS_IDX, 32'h0);
    wr(`TCC_CONTROL_IDX, ctl(2'h0, 1'b1, 1'b1, 1'b0, 1'b1, EDGE_NONE, EDGE_NONE, EDGE_RISE));
    c0 = conv_n;
    cap(2, 1'b1, 1'b1, 1'b0, v1);
    cap(2, 1'b0, 1'b1, 1'b0, q);
    cap(2, 1'b1, 1'b1, 1'b1, v2);
    rd("ch3 top", `TCC_TOP_IDX + 30'h2, v1);
    chk("starts", c0 + 1, conv_n);
    rd("flags", `TCC_FLAG_IDX, 32'h4);
    chk("masked request", 32'h0, {31'h0, capture_request});
    wr(`TCC_FLAG_IDX, 32'h4);
    wr(`TCC_CONTROL_IDX, ctl(2'h0, 1'b1, 1'b1, 1'b0, 1'b0, EDGE_NONE, EDGE_NONE, EDGE_RISE));
    cap(2, 1'b0, 1'b1, 1'b0, q);
    cap(2, 1'b1, 1'b1, 1'b1, q);
    chk("no start", c0 + 1, conv_n);
    wr(`TCC_CONTROL_IDX, 32'h0000_7FFC);
    rd("cleared", `TCC_STATUS_IDX, 32'h0);
    rd("cleared", `TCC_FLAG_IDX, 32'h0);
    $display("test trigger done");
  endtask : t_trig

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    t_reset;
    t_queue;
    t_same;
    t_pair;
    t_edges;
    t_trig;
    tally_and_finish;
  end
endmodule : tb_top
